/* File: core/mps_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module mps_mem #(
    parameter int AW = 10
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Access
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_lanes,
    input wire logic force_bad,
    // Read result, one cycle after rd_en
    output logic [15:0] rd_data,
    output logic rd_err
);

    logic [15:0] data_mem [2**AW];
    logic [1:0] par_mem [2**AW];
    logic [15:0] next_rd_data;
    logic next_rd_err;

    ////////////////////////////////////////////////////////////////////////////
    // Storage; only enabled lanes change, parity follows its lane
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            for (int i = 0; i < 2; i++) begin
                if (wr_lanes[i]) begin
                    data_mem[addr][i*8 +: 8] <= wr_data[i*8 +: 8];
                    par_mem[addr][i] <= mps_pkg::odd_par(wr_data[i*8 +: 8]) ^ force_bad;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read with check of both lanes; never-written words may flag, as in real RAM
    always_comb begin
        next_rd_data = rd_data;
        next_rd_err = 1'b0;
        if (rd_en) begin
            next_rd_data = data_mem[addr];
            next_rd_err = (par_mem[addr][0] != mps_pkg::odd_par(data_mem[addr][7:0]))
                || (par_mem[addr][1] != mps_pkg::odd_par(data_mem[addr][15:8]));
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 16'h0000;
            rd_err <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            rd_err <= next_rd_err;
        end
    end

    a_force_wrong: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_en && wr_lanes[0]) |=> par_mem[$past(addr)][0]
        == (mps_pkg::odd_par($past(wr_data[7:0])) ^ $past(force_bad)))
        else $error("stored parity does not follow force bit");

endmodule
`default_nettype wire

/* File: core/mps_pkg.sv */
// Overview of operation
// - A bus master reads and writes the parity control and status register at its assigned bus address.
// - The parity error flag in bit 15 goes to one on a parity error during a read or read-modify-write cycle.
// - The parity error flag is read/write, cleared by power-up or bus init, and otherwise stays set once set.
// - In the 128K-word configuration bit 14 ignores writes and always reads as zero.
// - In the 2048K-word configuration software may set bit 14 and reads it back as written.
// - In the 2048K-word configuration bit 14 is cleared by power-up or bus init.
// - While bit 14 is set, a register read returns the captured A18 to A21 in bits 05 to 08.
// - With bit 02 set, every word or byte write to memory stores inverted parity.
// - Bit 02 is read/write and cleared by power-up or bus init.
// - Reading a location written with bad parity, with reporting on, flags an error and captures its address.
// - With bit 00 set, a read parity error asserts data line 16, or lines 16 and 17 by strap, with the data.
// - Bit 00 is read/write and cleared by power-up or bus init.
package mps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus widths and default register address
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam logic [21:0] CSR_ADDR_DEF = 22'h3ff440;
    localparam logic [3:0] IO_PAGE_HI = 4'hf;

    ////////////////////////////////////////////////////////////////////////////
    // Register field positions
    localparam int BIT_PERR = 15;
    localparam int BIT_HI_SEL = 14;
    localparam int BIT_FORCE = 2;
    localparam int BIT_ERR_EN = 0;
    localparam int ERRADDR_LSB = 5;
    localparam int CAP_LSB = 11;
    localparam int CAP_W = 11;
    localparam int CAP_LO_W = 7;
    localparam int CAP_HI_W = 4;
    localparam int LINE16 = 16;
    localparam int LINE17 = 17;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [CAP_W-1:0] CAP_RESET = 11'h000;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic perr;
        logic hi_sel;
        logic force_bad;
        logic err_en;
    } mps_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic is_csr;
        logic is_mem;
    } mps_cycle_t;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic odd_par(input logic [7:0] b);
        return ~(^b);
    endfunction

    // Byte lanes of a write: both for a word, one chosen by A0 for a byte
    function automatic logic [1:0] write_lanes(input logic byte_wr, input logic a0);
        if (!byte_wr) begin
            return 2'h3;
        end
        return a0 ? 2'h2 : 2'h1;
    endfunction

    // Read image of the register
    function automatic logic [DATA_W-1:0] csr_image(input mps_ctrl_t c, input logic [CAP_W-1:0] cap);
        logic [DATA_W-1:0] v;
        v = 16'h0000;
        v[BIT_PERR] = c.perr;
        v[BIT_HI_SEL] = c.hi_sel;
        v[BIT_FORCE] = c.force_bad;
        v[BIT_ERR_EN] = c.err_en;
        if (c.hi_sel) begin
            v[ERRADDR_LSB +: CAP_HI_W] = cap[CAP_LO_W +: CAP_HI_W];
        end else begin
            v[ERRADDR_LSB +: CAP_LO_W] = cap[0 +: CAP_LO_W];
        end
        return v;
    endfunction

endpackage

/* File: core/mps_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module mps_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Asynchronous in, synchronous out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // First stage feeds only the second stage
    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    // Two flops against metastability
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end

endmodule
`default_nettype wire

/* File: core/mps_top.sv */
`timescale 1ns/10ps
`default_nettype none
module mps_top #(
    parameter logic [21:0] CSR_ADDR = mps_pkg::CSR_ADDR_DEF,
    parameter int MEM_AW = 10
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Bus control pins, high means asserted
    input wire logic bus_sync,
    input wire logic bus_din,
    input wire logic bus_dout,
    input wire logic bus_wtbt,
    input wire logic bus_init,
    input wire logic [21:0] bdal_in,
    // Configuration straps
    input wire logic strap_extended,
    input wire logic strap_report_both,
    // Bus drive
    output logic [17:0] bdal_out,
    output logic bdal_oe,
    output logic bus_rply,
    // Status indicator
    output logic parity_led
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SKIP,
        ST_ADDR,
        ST_FETCH,
        ST_RREPLY,
        ST_WREPLY
    } mps_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic s_sync;
    logic s_din;
    logic s_dout;
    logic s_wtbt;
    logic s_init;
    logic s_ext;
    logic s_both;
    logic [21:0] s_bdal;

    mps_sync #(
        .W(29)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d({bus_sync, bus_din, bus_dout, bus_wtbt, bus_init, strap_extended, strap_report_both, bdal_in}),
        .q({s_sync, s_din, s_dout, s_wtbt, s_init, s_ext, s_both, s_bdal})
    );

    ////////////////////////////////////////////////////////////////////////////
    // State
    mps_state_t state;
    mps_state_t next_state;
    mps_pkg::mps_cycle_t cyc;
    mps_pkg::mps_cycle_t next_cyc;
    mps_pkg::mps_ctrl_t ctrl;
    mps_pkg::mps_ctrl_t next_ctrl;
    logic [mps_pkg::CAP_W-1:0] cap;
    logic [mps_pkg::CAP_W-1:0] next_cap;
    logic [17:0] next_bdal_out;
    logic next_bdal_oe;
    logic next_rply;

    logic mem_wr;
    logic mem_rd;
    logic [15:0] mem_rd_data;
    logic mem_err;
    logic [1:0] lanes;
    logic csr_wr;
    logic csr_wr_hi;
    logic err_seen;
    logic hit_csr;
    logic hit_mem;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode; the register sits in the top page, upper bits only in wide mode
    always_comb begin
        hit_csr = (s_bdal[17:1] == CSR_ADDR[17:1])
            && (!s_ext || (s_bdal[21:18] == mps_pkg::IO_PAGE_HI));
        hit_mem = !hit_csr && (s_bdal[21:MEM_AW+1] == '0)
            && !(s_bdal[17:13] == 5'h1f && !s_ext);
    end

    // Strobes of the current data phase
    always_comb begin
        lanes = mps_pkg::write_lanes(s_wtbt, cyc.addr[0]);
        mem_wr = (state == ST_ADDR) && s_sync && !s_din && s_dout && cyc.is_mem;
        mem_rd = (state == ST_ADDR) && s_sync && s_din && cyc.is_mem;
        csr_wr = (state == ST_ADDR) && s_sync && !s_din && s_dout && cyc.is_csr;
        csr_wr_hi = csr_wr && lanes[1];
        err_seen = (state == ST_FETCH) && cyc.is_mem && mem_err;
    end

    mps_mem #(
        .AW(MEM_AW)
    ) u_mem (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr_en(mem_wr),
        .rd_en(mem_rd),
        .addr(cyc.addr[MEM_AW:1]),
        .wr_data(s_bdal[15:0]),
        .wr_lanes(lanes),
        .force_bad(ctrl.force_bad),
        .rd_data(mem_rd_data),
        .rd_err(mem_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencing; an unselected address is sat out until sync drops
    always_comb begin
        next_state = state;
        next_cyc = cyc;
        next_bdal_out = bdal_out;
        next_bdal_oe = bdal_oe;
        next_rply = bus_rply;
        unique case (state)
            ST_IDLE: begin
                if (s_sync) begin
                    next_cyc.addr = s_bdal;
                    next_cyc.is_csr = hit_csr;
                    next_cyc.is_mem = hit_mem;
                    next_state = (hit_csr || hit_mem) ? ST_ADDR : ST_SKIP;
                end
            end
            ST_SKIP: begin
                if (!s_sync) begin
                    next_state = ST_IDLE;
                end
            end
            ST_ADDR: begin
                if (!s_sync) begin
                    next_state = ST_IDLE;
                end else if (s_din) begin
                    next_state = ST_FETCH;
                end else if (s_dout) begin
                    next_rply = 1'b1;
                    next_state = ST_WREPLY;
                end
            end
            ST_FETCH: begin
                next_bdal_out = 18'h00000;
                if (cyc.is_csr) begin
                    next_bdal_out[15:0] = mps_pkg::csr_image(ctrl, cap);
                end else begin
                    next_bdal_out[15:0] = mem_rd_data;
                    next_bdal_out[mps_pkg::LINE16] = mem_err && ctrl.err_en;
                    next_bdal_out[mps_pkg::LINE17] = mem_err && ctrl.err_en && s_both;
                end
                next_bdal_oe = 1'b1;
                next_rply = 1'b1;
                next_state = ST_RREPLY;
            end
            ST_RREPLY: begin
                // Back to address state so a read-modify-write can follow
                if (!s_din) begin
                    next_bdal_oe = 1'b0;
                    next_rply = 1'b0;
                    next_bdal_out = 18'h00000;
                    next_state = ST_ADDR;
                end
            end
            ST_WREPLY: begin
                if (!s_dout) begin
                    next_rply = 1'b0;
                    next_state = ST_ADDR;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            cyc <= '0;
            bdal_out <= 18'h00000;
            bdal_oe <= 1'b0;
            bus_rply <= 1'b0;
        end else begin
            state <= next_state;
            cyc <= next_cyc;
            bdal_out <= next_bdal_out;
            bdal_oe <= next_bdal_oe;
            bus_rply <= next_rply;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits and error capture; an error beats a clearing write, init beats all
    always_comb begin
        next_ctrl = ctrl;
        next_cap = cap;
        if (csr_wr && lanes[0]) begin
            next_ctrl.force_bad = s_bdal[mps_pkg::BIT_FORCE];
            next_ctrl.err_en = s_bdal[mps_pkg::BIT_ERR_EN];
        end
        if (csr_wr_hi) begin
            next_ctrl.perr = s_bdal[mps_pkg::BIT_PERR];
            next_ctrl.hi_sel = s_ext && s_bdal[mps_pkg::BIT_HI_SEL];
        end
        if (err_seen) begin
            next_ctrl.perr = 1'b1;
            next_cap = cyc.addr[mps_pkg::CAP_LSB +: mps_pkg::CAP_W];
        end
        if (!s_ext) begin
            next_ctrl.hi_sel = 1'b0;
        end
        if (s_init) begin
            // Capture survives init so the failed address can still be read
            next_ctrl = '0;
        end
    end

    // Captured address has a defined value after power-up only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl <= {4{mps_pkg::CTRL_RESET}};
            cap <= mps_pkg::CAP_RESET;
        end else begin
            ctrl <= next_ctrl;
            cap <= next_cap;
        end
    end

    // Indicator comes straight off the flag flop
    assign parity_led = ctrl.perr;

    ////////////////////////////////////////////////////////////////////////////
    // Checks; each property looks one or two edges after its cause, except a_skip_silent, which checks on the same edge
    // A stuck read reply or a stray report line would hang or corrupt the master, so both are watched
    a_perr_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        (err_seen && !s_init) |=> ctrl.perr && cap == $past(cyc.addr[21:11]))
        else $error("parity error did not set flag and capture");

    a_perr_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ctrl.perr && !csr_wr_hi && !s_init) |=> ctrl.perr)
        else $error("parity flag dropped without write or init");

    a_init_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_init |=> (ctrl == '0) && !$changed(cap))
        else $error("init did not clear control bits or touched capture");

    a_hisel_narrow: assert property (@(posedge clk_sys) disable iff (!resetn)
        !s_ext |=> !ctrl.hi_sel)
        else $error("bit 14 set in narrow configuration");

    a_hisel_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (csr_wr_hi && s_ext && !s_init) |=> ctrl.hi_sel == $past(s_bdal[14]))
        else $error("bit 14 did not take written value");

    a_read_high: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == ST_FETCH && cyc.is_csr && ctrl.hi_sel)
        |=> bdal_out[8:5] == $past(cap[10:7]) && bdal_out[11:9] == 3'h0 && bdal_oe)
        else $error("high address bits not returned");

    a_read_low: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == ST_FETCH && cyc.is_csr && !ctrl.hi_sel) |=> bdal_out[11:5] == $past(cap[6:0]))
        else $error("low address bits not returned");

    a_unused_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == ST_FETCH && cyc.is_csr)
        |=> bdal_out[4:3] == 2'h0 && !bdal_out[1] && bdal_out[13:12] == 2'h0 && bdal_out[17:16] == 2'h0)
        else $error("unused register bits not zero");

    a_report_line: assert property (@(posedge clk_sys) disable iff (!resetn)
        err_seen |=> bdal_out[16] == $past(ctrl.err_en) && bdal_out[17] == $past(ctrl.err_en && s_both))
        else $error("error lines do not follow enable and strap");

    a_read_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == ST_ADDR && s_sync && s_din) |=> ##1 (bus_rply && bdal_oe))
        else $error("read not answered two cycles after strobe");

    a_write_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == ST_ADDR && s_sync && !s_din && s_dout) |=> bus_rply)
        else $error("write not answered one cycle after strobe");

    a_reply_release: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == ST_RREPLY && !s_din) |=> !bus_rply && !bdal_oe && bdal_out == 18'h00000)
        else $error("read reply not released after strobe dropped");

    a_skip_silent: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == ST_SKIP) |-> !bus_rply && !bdal_oe)
        else $error("unselected cycle was answered");

    a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (csr_wr && lanes[0] && !s_init)
        |=> ctrl.force_bad == $past(s_bdal[2]) && ctrl.err_en == $past(s_bdal[0]))
        else $error("low control bits did not take written value");

    a_report_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == ST_FETCH && !(cyc.is_mem && mem_err && ctrl.err_en)) |=> bdal_out[17:16] == 2'h0)
        else $error("error lines driven without enabled error");

    a_cap_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !err_seen |=> $stable(cap))
        else $error("captured address changed without parity error");

endmodule
`default_nettype wire

/* File: testbench/mps_bus_master.sv */
`timescale 1ns/10ps
`default_nettype none
module mps_bus_master (
    // Clock
    input wire logic clk_sys,
    // Device answer
    input wire logic [17:0] bdal_out,
    input wire logic bus_rply,
    // Bus drive
    output logic bus_sync,
    output logic bus_din,
    output logic bus_dout,
    output logic bus_wtbt,
    output logic [21:0] bdal_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        bus_sync = 1'b0;
        bus_din = 1'b0;
        bus_dout = 1'b0;
        bus_wtbt = 1'b0;
        bdal_in = 22'h000000;
    end

    // One whole bus cycle: address, strobe, wait for reply, release
    task automatic cycle(input logic wr, input logic bw, input logic [21:0] a, input logic [15:0] d,
                         output logic [17:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q = 18'h00000;
        @(posedge clk_sys);
        bus_sync <= 1'b1; // Address phase first
        bdal_in <= a;
        repeat (4) @(posedge clk_sys);
        // Released lines on a read show the inverse address
        bdal_in <= wr ? {6'h00, d} : ~a;
        bus_wtbt <= bw;
        // Data steady three cycles before the strobe
        repeat (3) @(posedge clk_sys);
        if (wr) begin
            bus_dout <= 1'b1;
        end else begin
            bus_din <= 1'b1;
        end
        // Hold the strobe until reply is sampled high or 20 edges pass, take data on that edge
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk_sys);
            if (bus_rply === 1'b1) begin
                ok = 1'b1;
                q = bdal_out;
            end
        end
        bus_din <= 1'b0;
        bus_dout <= 1'b0;
        for (n = 0; n < 20 && bus_rply !== 1'b0; n++) begin
            @(posedge clk_sys);
        end
        ok = ok && (bus_rply === 1'b0);
        bus_sync <= 1'b0;
        bus_wtbt <= 1'b0;
        bdal_in <= ~bdal_in;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_mps_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_mps_top;
    typedef struct packed {
        logic ext;
        logic [15:0] wr;
        logic [15:0] rd;
    } mps_row_t;

    localparam logic [21:0] PARITY_CONTROL_STATUS = mps_pkg::CSR_ADDR_DEF;
    localparam logic [21:0] BAD_LOC = 22'h001800;
    logic clk_sys;
    logic resetn;
    logic bus_init;
    logic strap_ext;
    logic strap_both;
    logic bus_sync;
    logic bus_din;
    logic bus_dout;
    logic bus_wtbt;
    logic [21:0] bdal_in;
    logic [17:0] bdal_out;
    logic bdal_oe;
    logic bus_rply;
    logic parity_led;
    int bad_count;
    int samples_checked;
    // Register rows: strap, value written, value read back
    mps_row_t rows [4] = '{'{1'b0, 16'hffff, 16'h8005}, '{1'b0, 16'h0000, 16'h0000},
                           '{1'b1, 16'h7ffd, 16'h4005}, '{1'b1, 16'h0004, 16'h0004}};

    ////////////////////////////////////////////////////////////////////////////
    // Design and bus master; memory widened so A11 and A12 can be captured
    mps_top #(.MEM_AW(12)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .bus_sync(bus_sync), .bus_din(bus_din),
        .bus_dout(bus_dout), .bus_wtbt(bus_wtbt), .bus_init(bus_init), .bdal_in(bdal_in),
        .strap_extended(strap_ext), .strap_report_both(strap_both), .bdal_out(bdal_out),
        .bdal_oe(bdal_oe), .bus_rply(bus_rply), .parity_led(parity_led)
    );
    mps_bus_master master_u (
        .clk_sys(clk_sys), .bdal_out(bdal_out), .bus_rply(bus_rply), .bus_sync(bus_sync),
        .bus_din(bus_din), .bus_dout(bus_dout), .bus_wtbt(bus_wtbt), .bdal_in(bdal_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // A missing reply ends the run at once
    task automatic wr(input logic bw, input logic [21:0] a, input logic [15:0] d);
        logic [17:0] q;
        logic ok;
        master_u.cycle(1'b1, bw, a, d, q, ok);
        check("write reply", {17'h0, ok}, 18'h1);
        if (ok !== 1'b1) end_of_test();
    endtask

    task automatic rd(input logic [21:0] a, input logic [17:0] e);
        logic [17:0] q;
        logic ok;
        master_u.cycle(1'b0, 1'b0, a, 16'h0000, q, ok);
        check("read reply", {17'h0, ok}, 18'h1);
        if (ok !== 1'b1) end_of_test();
        check("read data", q, e);
    endtask

    task automatic set_straps(input logic ext, input logic both);
        strap_ext <= ext;
        strap_both <= both;
        repeat (3) @(posedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [17:0] q;
        logic ok;
        bad_count = 0;
        samples_checked = 0;
        resetn = 1'b0;
        bus_init = 1'b0;
        strap_ext = 1'b0;
        strap_both = 1'b0;
        repeat (2) @(posedge clk_sys);
        check("reset drive", {15'h0, bdal_oe, bus_rply, parity_led}, 18'h0);
        @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(PARITY_CONTROL_STATUS, 18'h00000);
        for (int i = 0; i < 4; i++) begin
            set_straps(rows[i].ext, 1'b0);
            wr(1'b0, PARITY_CONTROL_STATUS, rows[i].wr);
            rd(PARITY_CONTROL_STATUS, {2'b00, rows[i].rd});
        end
        // Unmapped places get no reply at all
        master_u.cycle(1'b0, 1'b0, 22'h200000, 16'h0000, q, ok);
        check("unmapped reply", {17'h0, ok}, 18'h0);
        master_u.cycle(1'b1, 1'b0, PARITY_CONTROL_STATUS + 22'h2, 16'h0001, q, ok);
        check("neighbour reply", {17'h0, ok}, 18'h0);
        // Forced bad parity on a word write, then report on line 16 only
        set_straps(1'b0, 1'b0);
        wr(1'b0, PARITY_CONTROL_STATUS, 16'h0004);
        wr(1'b0, BAD_LOC, 16'ha5a5);
        wr(1'b0, PARITY_CONTROL_STATUS, 16'h0001);
        rd(BAD_LOC, {2'b01, 16'ha5a5});
        rd(PARITY_CONTROL_STATUS, 18'h08061);
        check("led", {17'h0, parity_led}, 18'h1);
        wr(1'b0, PARITY_CONTROL_STATUS, 16'h0000);
        rd(PARITY_CONTROL_STATUS, 18'h00060);
        rd(BAD_LOC, {2'b00, 16'ha5a5});
        rd(PARITY_CONTROL_STATUS, 18'h08060);
        // Upper capture bits selected, low capture hidden
        set_straps(1'b1, 1'b0);
        wr(1'b0, PARITY_CONTROL_STATUS, 16'h4000);
        rd(PARITY_CONTROL_STATUS, 18'h04000);
        wr(1'b0, PARITY_CONTROL_STATUS, 16'h0001);
        rd(PARITY_CONTROL_STATUS, 18'h00061);
        // Byte write with force on, both report lines
        set_straps(1'b0, 1'b1);
        wr(1'b0, 22'h000002, 16'h1234);
        wr(1'b0, PARITY_CONTROL_STATUS, 16'h0005);
        wr(1'b1, 22'h000003, 16'hab00);
        wr(1'b0, PARITY_CONTROL_STATUS, 16'h0001);
        rd(22'h000002, {2'b11, 16'hab34});
        rd(PARITY_CONTROL_STATUS, 18'h08001);
        wr(1'b0, 22'h000004, 16'h0f0f);
        rd(22'h000004, {2'b00, 16'h0f0f});
        rd(PARITY_CONTROL_STATUS, 18'h08001);
        // Bus init clears control bits in the large configuration
        set_straps(1'b1, 1'b1);
        wr(1'b0, PARITY_CONTROL_STATUS, 16'hc005);
        rd(PARITY_CONTROL_STATUS, 18'h0c005);
        @(posedge clk_sys);
        bus_init <= 1'b1;
        repeat (4) @(posedge clk_sys);
        bus_init <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(PARITY_CONTROL_STATUS, 18'h00000);
        check("led after init", {17'h0, parity_led}, 18'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
